// >>> otgbs_host_model.sv
// Host controller on the link side: strobes latch reads and captures data.
// Assumes a free-running link clock; reads are spaced four cycles or more.
`timescale 1ns/100ps

module otgbs_host_model (
  input  wire logic                   link_clk, // Link clock
  input  wire logic [2:0]             latch_q,  // Latch read data
  input  wire otgbs_pkg::otgbs_comp_t status_q, // Status read data
  input  wire logic                   role_q,   // Role read data
  output logic                        rd,       // Latch read strobe
  output logic                        done,     // Capture pulse
  output logic [6:0]                  data      // Role, status, latch
);
  import otgbs_pkg::*;

  initial begin
    rd = 1'b0;
    done = 1'b0;
    data = 7'h00;
  end

  // Gap stretches the idle time after a read to model a slow host
  task automatic read_latch(input int gap);
    @(posedge link_clk);
    rd <= 1'b1;
    @(posedge link_clk);
    rd <= 1'b0;
    repeat (2) @(posedge link_clk);
    data <= {role_q, status_q, latch_q};
    done <= 1'b1;
    @(posedge link_clk);
    done <= 1'b0;
    repeat (gap) @(posedge link_clk);
  endtask
endmodule

// >>> otgbs_map.svh
// Constants of the bus status and interrupt block: bit positions of the
// status and latch words, shutdown timing and the core clock rate.
// Included by the package and by every design file that needs a figure.
`ifndef OTGBS_MAP_SVH
`define OTGBS_MAP_SVH

`define OTGBS_NEV            3
`define OTGBS_BIT_BUS_PWR    0
`define OTGBS_BIT_SESS_LIVE  1
`define OTGBS_BIT_SESS_OVER  2
`define OTGBS_EVT_NONE       3'h0
`define OTGBS_SYNC_RST       1'h0
`define OTGBS_CLK_MHZ        250
`define OTGBS_ENTER_SD_US    1000
`define OTGBS_EXIT_SD_US     500
`define OTGBS_ENTER_SD_CYC   (`OTGBS_ENTER_SD_US * `OTGBS_CLK_MHZ)
`define OTGBS_EXIT_SD_CYC    (`OTGBS_EXIT_SD_US * `OTGBS_CLK_MHZ)
`define OTGBS_CNT_W          32

`endif

// >>> otgbs_pkg.sv
// Types shared by the bus status and interrupt block.
// The mask field width comes from the constants header.
`include "otgbs_map.svh"

package otgbs_pkg;

  // Bit 0 power good, bit 1 session live, bit 2 session over
  typedef struct packed {
    logic session_over;
    logic session_live;
    logic bus_power_good;
  } otgbs_comp_t;

  typedef struct packed {
    logic                     irq_push_pull; // 0 open drain (default)
    logic                     power_down;    // Shutdown request
    logic [`OTGBS_NEV-1:0]    mask;          // Per event enable
    logic [1:0]               edge_rise;     // Bits 0,1: 1 rising, 0 fall
  } otgbs_cfg_t;

  typedef enum logic [1:0] {
    OTGBS_PM_RUN,
    OTGBS_PM_ENTER,
    OTGBS_PM_DOWN,
    OTGBS_PM_WAKE
  } otgbs_pm_t;

endpackage

// >>> otgbs_props.sv
// Checker of the bus status block: pin, event and shutdown relations.
// Sees only the top module's ports; bound into the top below.
`timescale 1ns/100ps
`include "otgbs_map.svh"

module otgbs_props
  import otgbs_pkg::*;
#(
  parameter int ENTER_CYC = `OTGBS_ENTER_SD_CYC,
  parameter int EXIT_CYC  = `OTGBS_EXIT_SD_CYC
) (
  input wire logic                   clk,             // Core clock
  input wire logic                   rst_b,           // Reset
  input wire logic                   ce,              // Enable
  input wire otgbs_pkg::otgbs_comp_t comp_raw,        // Comparators
  input wire logic                   cable_role_in,   // Role pin
  input wire otgbs_pkg::otgbs_cfg_t  cfg,             // Control
  input wire otgbs_pkg::otgbs_comp_t status,          // Status
  input wire logic [`OTGBS_NEV-1:0]  latch,           // Latch
  input wire logic                   cable_role_out,  // Role out
  input wire logic                   comp_enable,     // Comp power
  input wire logic                   in_shutdown,     // Shutdown
  input wire logic                   irq_n_o,         // Irq level
  input wire logic                   irq_oe,          // Irq drive
  input wire logic                   link_clk,        // Link clock
  input wire logic                   link_latch_rd,   // Latch read
  input wire logic [`OTGBS_NEV-1:0]  link_latch_q,    // Latch data
  input wire otgbs_pkg::otgbs_comp_t link_status_q,   // Status data
  input wire logic                   link_cable_role, // Role data
  input wire logic                   link_shutdown    // Shutdown data
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_pg_edge;
    $rose(status.bus_power_good) && cfg.edge_rise[0] ||
    $fell(status.bus_power_good) && !cfg.edge_rise[0];
  endsequence
  sequence s_sl_edge;
    $rose(status.session_live) && cfg.edge_rise[1] ||
    $fell(status.session_live) && !cfg.edge_rise[1];
  endsequence

  AST_IRQ_DRIVEN: assert property (!irq_n_o |-> irq_oe)
    else $error("irq low while not driven");
  AST_PUSH_PULL: assert property (ce && cfg.irq_push_pull |=> irq_oe)
    else $error("push-pull pin not driven");
  AST_OPEN_DRAIN: assert property (
    ce && !cfg.irq_push_pull |=> irq_oe == !irq_n_o)
    else $error("open drain drive wrong");
  AST_ROLE_MIRROR: assert property (
    ce[*3] |-> cable_role_out == $past(cable_role_in, 2))
    else $error("role output lags wrongly");
  AST_STATUS_FOLLOW: assert property (
    ce[*4] ##0 $changed(status) |-> status == $past(comp_raw, 3))
    else $error("status not from comparators");
  AST_PG_EVENT: assert property (s_pg_edge ##0 cfg.mask[0] |-> latch[0])
    else $error("power good event lost");
  AST_SL_EVENT: assert property (s_sl_edge ##0 cfg.mask[1] |-> latch[1])
    else $error("session live event lost");
  AST_SO_EVENT: assert property (
    $rose(status.session_over) && cfg.mask[2] |-> latch[2])
    else $error("session over event lost");
  AST_MASKED: assert property (
    ce && !cfg.mask[0] && !latch[0] |=> !latch[0])
    else $error("masked event latched");
  AST_IRQ_SET: assert property (ce && latch != 3'h0 |=> !irq_n_o)
    else $error("pending event without irq");
  AST_IRQ_FREE: assert property (ce && latch == 3'h0 |=> irq_n_o)
    else $error("irq held without event");
  AST_PD_OFF: assert property (
    ce && $rose(cfg.power_down) |=> !comp_enable)
    else $error("comparators stay on");
  AST_SD_ENTER: assert property (
    $rose(in_shutdown) |->
      !$past(comp_enable, ENTER_CYC) && $past(comp_enable, ENTER_CYC + 1))
    else $error("shutdown reached at wrong time");
endmodule

bind otgbs_top otgbs_props #(
  .ENTER_CYC(ENTER_CYC), .EXIT_CYC(EXIT_CYC)) u_props (
  .clk(clk), .rst_b(rst_b), .ce(ce), .comp_raw(comp_raw),
  .cable_role_in(cable_role_in), .cfg(cfg), .status(status), .latch(latch),
  .cable_role_out(cable_role_out), .comp_enable(comp_enable),
  .in_shutdown(in_shutdown), .irq_n_o(irq_n_o), .irq_oe(irq_oe),
  .link_clk(link_clk), .link_latch_rd(link_latch_rd),
  .link_latch_q(link_latch_q), .link_status_q(link_status_q),
  .link_cable_role(link_cable_role), .link_shutdown(link_shutdown));

// >>> otgbs_pulse_xfer.sv
// Carries a one-cycle pulse from one clock domain to another by a toggle.
// Assumes source pulses are spaced wider than three destination cycles.
`timescale 1ns/100ps
`include "otgbs_map.svh"

module otgbs_pulse_xfer (
  input  wire logic src_clk,    // Source clock
  input  wire logic dst_clk,    // Destination clock
  input  wire logic rst_b,      // Async reset, active low
  input  wire logic dst_en,     // Destination clock enable
  input  wire logic src_pulse,  // One-cycle pulse, source domain
  output logic      dst_pulse   // One-cycle pulse, destination domain
);

  logic tog_reg;
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge src_clk or negedge rst_b) begin
    if (!rst_b) begin
      tog_reg <= `OTGBS_SYNC_RST;
    end else if (src_pulse) begin
      tog_reg <= ~tog_reg;
    end
  end

  always_ff @(posedge dst_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_reg <= `OTGBS_SYNC_RST;
      s2_reg <= `OTGBS_SYNC_RST;
      s3_reg <= `OTGBS_SYNC_RST;
    end else if (dst_en) begin
      s1_reg <= tog_reg;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Only the second and third stages feed the detector
  assign dst_pulse = dst_en & (s2_reg ^ s3_reg);

endmodule

// >>> otgbs_sync.sv
// Two flip-flop level synchroniser of parameter width.
// Assumes each bit is an independent level; no word coherence is given.
`timescale 1ns/100ps
`include "otgbs_map.svh"

module otgbs_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,    // Destination clock
  input  wire logic         rst_b,  // Async reset, active low
  input  wire logic         en,     // Clock enable
  input  wire logic [W-1:0] d,      // Asynchronous input
  output logic      [W-1:0] q       // Synchronised output
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= {W{`OTGBS_SYNC_RST}};
      q_reg    <= {W{`OTGBS_SYNC_RST}};
    end else if (en) begin
      meta_reg <= d;
      q_reg    <= meta_reg;
    end
  end

  assign q = q_reg;

endmodule

// >>> otgbs_top.sv
// Bus supply status and interrupt logic of a dual-role companion device.
// Assumes comparator outputs and the cable role pin are asynchronous, and
// that host logic on link_clk issues latch reads spaced by at least two
// link clock periods while ce is high.
`timescale 1ns/100ps
`include "otgbs_map.svh"

module otgbs_top
  import otgbs_pkg::*;
#(
  parameter int ENTER_CYC = `OTGBS_ENTER_SD_CYC,
  parameter int EXIT_CYC  = `OTGBS_EXIT_SD_CYC
) (
  input  wire logic                  clk,             // Core clock 250 MHz
  input  wire logic                  rst_b,           // Async reset
  input  wire logic                  ce,              // Core clock enable
  input  wire otgbs_pkg::otgbs_comp_t comp_raw,       // Comparator outputs
  input  wire logic                  cable_role_in,   // Cable role pin
  input  wire otgbs_pkg::otgbs_cfg_t cfg,             // Control bits
  output otgbs_pkg::otgbs_comp_t     status,          // Bus status word
  output logic [`OTGBS_NEV-1:0]      latch,           // Pending events
  output logic                       cable_role_out,  // Mirrored role pin
  output logic                       comp_enable,     // Comparator power
  output logic                       in_shutdown,     // Shutdown reached
  output logic                       irq_n_o,         // Interrupt pin level
  output logic                       irq_oe,          // Interrupt pin drive
  input  wire logic                  link_clk,        // Serial link clock
  input  wire logic                  link_latch_rd,   // Host reads latch
  output logic [`OTGBS_NEV-1:0]      link_latch_q,    // Latch read data
  output otgbs_pkg::otgbs_comp_t     link_status_q,   // Status read data
  output logic                       link_cable_role, // Role read data
  output logic                       link_shutdown    // Shutdown read data
);

  import otgbs_pkg::*;

  localparam logic [`OTGBS_CNT_W-1:0] ENTER_LD =
    `OTGBS_CNT_W'(ENTER_CYC - 1);
  localparam logic [`OTGBS_CNT_W-1:0] EXIT_LD =
    `OTGBS_CNT_W'(EXIT_CYC - 1);

  // Rising or falling edge of one bit, chosen by rise
  function automatic logic edge_hit(input logic now_v, input logic old_v,
                                    input logic rise);
    edge_hit = rise ? (now_v & ~old_v) : (~now_v & old_v);
  endfunction

  // ---------------- Core clock domain ----------------

  logic [`OTGBS_NEV-1:0] comp_sync;
  logic                  role_sync;
  logic                  rd_pulse;

  otgbs_sync #(.W(`OTGBS_NEV)) u_comp_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .en    (ce),
    .d     (comp_raw),
    .q     (comp_sync)
  );

  // The mirror lags the pin by two core cycles; ce held low stretches it.
  otgbs_sync #(.W(1)) u_role_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .en    (ce),
    .d     (cable_role_in),
    .q     (role_sync)
  );

  // Latch reads cross as a toggle; reads must be spaced so that each
  // toggle is seen here before the next one arrives.
  otgbs_pulse_xfer u_rd_xfer (
    .src_clk   (link_clk),
    .dst_clk   (clk),
    .rst_b     (rst_b),
    .dst_en    (ce),
    .src_pulse (link_latch_rd),
    .dst_pulse (rd_pulse)
  );

  // Power management sequence
  otgbs_pm_t              pm_reg;
  otgbs_pm_t              pm_next;
  logic [`OTGBS_CNT_W-1:0] pm_cnt_reg;
  logic                   cnt_zero;

  assign cnt_zero = (pm_cnt_reg == '0);

  always_comb begin
    pm_next = pm_reg;
    unique case (pm_reg)
      OTGBS_PM_RUN: begin
        if (cfg.power_down) begin
          pm_next = OTGBS_PM_ENTER;
        end
      end
      OTGBS_PM_ENTER: begin
        if (!cfg.power_down) begin
          pm_next = OTGBS_PM_WAKE;
        end else if (cnt_zero) begin
          pm_next = OTGBS_PM_DOWN;
        end
      end
      OTGBS_PM_DOWN: begin
        if (!cfg.power_down) begin
          pm_next = OTGBS_PM_WAKE;
        end
      end
      OTGBS_PM_WAKE: begin
        if (cfg.power_down) begin
          pm_next = OTGBS_PM_ENTER;
        end else if (cnt_zero) begin
          pm_next = OTGBS_PM_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pm_reg <= OTGBS_PM_RUN;
    end else if (ce) begin
      pm_reg <= pm_next;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pm_cnt_reg <= '0;
    end else if (ce) begin
      if (pm_next == OTGBS_PM_ENTER && pm_reg != OTGBS_PM_ENTER) begin
        pm_cnt_reg <= ENTER_LD;
      end else if (pm_next == OTGBS_PM_WAKE && pm_reg != OTGBS_PM_WAKE) begin
        pm_cnt_reg <= EXIT_LD;
      end else if (!cnt_zero) begin
        pm_cnt_reg <= pm_cnt_reg - 1'b1;
      end
    end
  end

  // Comparators are cut one cycle after shutdown is asked for and come back
  // when it is lifted; their outputs are ignored until settled.
  logic comps_live;
  assign comp_enable = (pm_reg == OTGBS_PM_RUN) ||
                       (pm_reg == OTGBS_PM_WAKE);
  assign comps_live  = (pm_reg == OTGBS_PM_RUN) && !cfg.power_down;
  assign in_shutdown = (pm_reg == OTGBS_PM_DOWN);

  // Shutdown flag leaves this domain from a flop, never from the state
  // decode, so a state change cannot glitch into the far synchroniser.
  logic sd_flag_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sd_flag_reg <= 1'b0;
    end else if (ce) begin
      sd_flag_reg <= (pm_next == OTGBS_PM_DOWN);
    end
  end

  // Status word holds its last value while the comparators are off, so
  // leaving shutdown cannot fake an edge.
  otgbs_comp_t status_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status_reg <= '0;
    end else if (ce && comps_live) begin
      status_reg.bus_power_good <= comp_sync[`OTGBS_BIT_BUS_PWR];
      status_reg.session_live   <= comp_sync[`OTGBS_BIT_SESS_LIVE];
      status_reg.session_over   <= comp_sync[`OTGBS_BIT_SESS_OVER];
    end
  end

  assign status = status_reg;

  // Edges are taken between the stored status and the new synced value,
  // so each transition is seen in exactly one cycle.
  logic [`OTGBS_NEV-1:0] evt;

  always_comb begin
    evt = `OTGBS_EVT_NONE;
    if (comps_live) begin
      evt[`OTGBS_BIT_BUS_PWR] = edge_hit(comp_sync[`OTGBS_BIT_BUS_PWR],
        status_reg.bus_power_good,
        cfg.edge_rise[`OTGBS_BIT_BUS_PWR]);
      evt[`OTGBS_BIT_SESS_LIVE] = edge_hit(comp_sync[`OTGBS_BIT_SESS_LIVE],
        status_reg.session_live,
        cfg.edge_rise[`OTGBS_BIT_SESS_LIVE]);
      // Session over rises when the supply falls below its threshold
      evt[`OTGBS_BIT_SESS_OVER] = edge_hit(comp_sync[`OTGBS_BIT_SESS_OVER],
        status_reg.session_over, 1'b1);
    end
  end

  // Latch read clears only what the host actually saw; a new event in the
  // same cycle wins over the clear.
  logic [`OTGBS_NEV-1:0] latch_reg;
  logic [`OTGBS_NEV-1:0] link_snap_reg;
  logic [`OTGBS_NEV-1:0] clr_mask;

  assign clr_mask = rd_pulse ? link_snap_reg : `OTGBS_EVT_NONE;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      latch_reg <= `OTGBS_EVT_NONE;
    end else if (ce) begin
      latch_reg <= (latch_reg & ~clr_mask) | (evt & cfg.mask);
    end
  end

  assign latch = latch_reg;

  // Interrupt pin, registered
  logic irq_act_reg;
  logic irq_oe_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_act_reg <= 1'b0;
      irq_oe_reg  <= 1'b0;
    end else if (ce) begin
      irq_act_reg <= |latch_reg;
      // Open drain only drives while low; push-pull drives always
      irq_oe_reg  <= cfg.irq_push_pull | (|latch_reg);
    end
  end

  assign irq_n_o = ~irq_act_reg;
  assign irq_oe  = irq_oe_reg;

  assign cable_role_out = role_sync;

  // ---------------- Link clock domain ----------------

  logic [`OTGBS_NEV-1:0] link_latch_s;
  logic [`OTGBS_NEV-1:0] link_stat_s;
  logic [1:0]            link_misc_s;

  otgbs_sync #(.W(`OTGBS_NEV)) u_link_latch_sync (
    .clk   (link_clk),
    .rst_b (rst_b),
    .en    (1'b1),
    .d     (latch_reg),
    .q     (link_latch_s)
  );

  otgbs_sync #(.W(`OTGBS_NEV)) u_link_stat_sync (
    .clk   (link_clk),
    .rst_b (rst_b),
    .en    (1'b1),
    .d     (status_reg),
    .q     (link_stat_s)
  );

  otgbs_sync #(.W(2)) u_link_misc_sync (
    .clk   (link_clk),
    .rst_b (rst_b),
    .en    (1'b1),
    .d     ({cable_role_in, sd_flag_reg}),
    .q     (link_misc_s)
  );

  // Snapshot stays stable until the next read, so the core domain may
  // read it once the read event has crossed.
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      link_snap_reg <= `OTGBS_EVT_NONE;
    end else if (link_latch_rd) begin
      link_snap_reg <= link_latch_s;
    end
  end

  otgbs_comp_t link_stat_reg;
  logic        link_role_reg;
  logic        link_sd_reg;

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      link_stat_reg <= '0;
      link_role_reg <= 1'b0;
      link_sd_reg   <= 1'b0;
    end else begin
      link_stat_reg <= link_stat_s;
      link_role_reg <= link_misc_s[1];
      link_sd_reg   <= link_misc_s[0];
    end
  end

  assign link_latch_q    = link_snap_reg;
  assign link_status_q   = link_stat_reg;
  assign link_cable_role = link_role_reg;
  assign link_shutdown   = link_sd_reg;

endmodule

// >>> tb.sv
// Self-checking bench of the bus status block with a link-side host.
// Assumes the design files and the checker are compiled before it.
`timescale 1ns/100ps
`include "otgbs_map.svh"

module tb;
  import otgbs_pkg::*;
  logic        clk, link_clk, rst_b, role, pin, role_o, comp_en, in_sd;
  logic        irq_n, irq_oe, rd, lrole, lsd, done, ce;
  otgbs_comp_t raw, status, lst, st;
  otgbs_cfg_t  cfg;
  logic [2:0]  latch, lq, ev;
  logic [6:0]  hdata;
  logic [6:0]  exp_q[$];
  int          mismatches = 0;
  int          n_checks = 0;
  int          cyc = 0;

  otgbs_top #(.ENTER_CYC(20), .EXIT_CYC(10)) dut (
    .clk(clk), .rst_b(rst_b), .ce(ce), .comp_raw(raw),
    .cable_role_in(role), .cfg(cfg), .status(status), .latch(latch),
    .cable_role_out(role_o), .comp_enable(comp_en), .in_shutdown(in_sd),
    .irq_n_o(irq_n), .irq_oe(irq_oe), .link_clk(link_clk),
    .link_latch_rd(rd), .link_latch_q(lq), .link_status_q(lst),
    .link_cable_role(lrole), .link_shutdown(lsd));
  otgbs_host_model host (.link_clk(link_clk), .latch_q(lq), .status_q(lst),
    .role_q(lrole), .rd(rd), .done(done), .data(hdata));

  // Open drain pin has a pull-up
  assign pin = irq_oe ? irq_n : 1'b1;

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #7.3;
    forever #62.5 link_clk = ~link_clk;
  end

  task automatic chk_rd(input logic [6:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, exp, input string m);
    chk_rd({6'h00, got}, {6'h00, exp}, m);
  endtask

  always @(posedge link_clk)
    if (done === 1'b1)
      chk_rd(hdata, exp_q.pop_front(), "read");

  task automatic rd_exp(input logic [2:0] l);
    exp_q.push_back({role, st, l});
    host.read_latch($urandom_range(3));
    chk_bit(pin, 1'b1, "clear");
  endtask

  task automatic step(input otgbs_comp_t r, input logic [1:0] er,
                      input logic [2:0] m);
    @(negedge clk);
    cfg.edge_rise = er;
    cfg.mask = m;
    raw = r;
    role = 1'($urandom);
    ev[0] = st[0] != r[0] && r[0] == er[0];
    ev[1] = st[1] != r[1] && r[1] == er[1];
    ev[2] = !st[2] && r[2];
    ev = ev & m;
    st = r;
    repeat (100) @(negedge clk);
    chk_bit(pin, ev == 3'h0, "pin");
    chk_rd({4'h0, latch}, {4'h0, ev}, "latch");
    chk_bit(role_o, role, "role");
    rd_exp(ev);
  endtask

  task automatic give_verdict();
    $display("mismatches %0d n_checks %0d", mismatches, n_checks);
    if (mismatches == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      give_verdict();
    end
  end

  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    role = 1'b0;
    raw = 3'h0;
    st = 3'h0;
    cfg = '{1'b0, 1'b0, 3'h7, 2'h3};
    void'($urandom(32'hEEFC69CA));
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    step(3'h4, 2'h3, 3'h7);
    for (int i = 0; i < 16; i++)
      step(otgbs_comp_t'(3'($urandom)), i[1:0], 3'h7);
    step(~st, 2'h3, 3'h0);
    @(negedge clk) cfg.irq_push_pull = 1'b1;
    repeat (2) @(negedge clk);
    chk_bit(irq_oe, 1'b1, "drive");
    step(~st, 2'h0, 3'h7);
    @(negedge clk) cfg.power_down = 1'b1;
    repeat (30) @(negedge clk);
    chk_bit(in_sd, 1'b1, "down");
    chk_bit(comp_en, 1'b0, "comp off");
    raw = ~st;
    repeat (100) @(negedge clk);
    chk_bit(lsd, 1'b1, "link down");
    rd_exp(3'h0);
    @(negedge clk) cfg.power_down = 1'b0;
    step(raw, 2'h3, 3'h7);
    // Clock enable low: a comparator change must wait until it returns
    @(negedge clk) ce = 1'b0;
    raw = ~st;
    repeat (10) @(negedge clk);
    chk_bit(status == st, 1'b1, "frozen");
    ce = 1'b1;
    step(raw, 2'h0, 3'h7);
    give_verdict();
  end
endmodule
